// ===== dv/dram_on_die_termination_ctrl_bench.sv
// Bench for the termination controller: registers, latency, strength.
// Assumes odt_host_model plays the controller on the ODT pin.
`timescale 1ns/1ps
`include "odt_cfg.svh"
module dram_on_die_termination_ctrl_bench;
  logic clock_i = 1'b0; // 100 MHz
  logic reset_i = 1'b1; // Held three cycles
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sel_wr, e;
  logic self_ref = 1'b0, dll_lock = 1'b1, pd_pre = 1'b0, dq_drv = 1'b0; // Device state
  logic start = 1'b0, m_wr = 1'b0, m_bc4 = 1'b0, dll_off = 1'b0; // Model requests
  logic [7:0] m_len = 8'h00;
  logic odt_pin, wr_cmd, wr_bc4;
  logic [1:0] term_en;
  logic [2:0] rtt_code;
  int error_cnt = 0, check_count = 0, n;

  always #5 clock_i = ~clock_i;

  odt_ctrl #(.LANES(2), .MAX_LAT(32)) odt_ctrl_inst (
    .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .odt_pin_i(odt_pin), .wr_cmd_i(wr_cmd),
    .wr_bc4_i(wr_bc4), .self_refresh_i(self_ref), .dll_locked_i(dll_lock),
    .pd_precharge_i(pd_pre), .dq_driving_i(dq_drv), .term_en_o(term_en),
    .rtt_code_o(rtt_code), .sel_wr_o(sel_wr));

  odt_host_model odt_host_model_inst (
    .clock_i(clock_i), .reset_i(reset_i), .start_i(start), .len_i(m_len), .wr_i(m_wr),
    .bc4_i(m_bc4), .dll_off_i(dll_off), .odt_pin_o(odt_pin), .wr_cmd_o(wr_cmd),
    .wr_bc4_o(wr_bc4));

  // Verdict, reached from the end of the sequence or a spent wait
  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Case-equal compare so an unknown never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      complete_run();
    end
  endtask : apb

  // Configuration word built in register layout
  task automatic set_cfg(input logic [2:0] nom, input logic [1:0] wr, input logic [3:0] cwl,
                         input logic [4:0] al, input logic [1:0] bst, input logic keep);
    odt_pkg::cfg_t c;
    c = {keep, bst, al, cwl, wr, nom};
    apb(1'b1, `ODT_CFG_OFS, {15'h0000, c});
  endtask : set_cfg

  // Ask the model for one ODT pulse; returns at the edge that raises it
  task automatic pulse(input logic [7:0] len, input logic wr, input logic bc4);
    @(posedge clock_i);
    start <= 1'b1;
    m_len <= len;
    m_wr <= wr;
    m_bc4 <= bc4;
    @(posedge clock_i);
    start <= 1'b0;
  endtask : pulse

  // Edges until term (0) or write select (1) reads v, bounded
  task automatic wait_for(input logic which, input logic v, output int k);
    logic s;
    k = 0;
    do begin
      @(posedge clock_i);
      #1;
      k++;
      s = which ? sel_wr : term_en[0];
    end while (s !== v && k < 80);
    if (k >= 80) begin
      error_cnt++;
      complete_run();
    end
  endtask : wait_for

  // ODT pulse, with a write if asked; watched outputs must stay low
  task automatic quiet(input string what, input logic watch_term, input logic wr);
    logic moved;
    moved = 1'b0;
    pulse(8'h08, wr, 1'b0);
    repeat (20) begin
      @(posedge clock_i);
      #1;
      moved = moved | (watch_term & term_en[0]) | sel_wr;
    end
    check(what, {31'h0, moved}, 32'h0);
  endtask : quiet

  // Reset values, read-only status, unmapped address
  task automatic t_regs();
    apb(1'b0, `ODT_CFG_OFS, 32'h0);
    check("cfg reset", q, 32'h000000a0);
    check("mapped ok", {31'h0, e}, 32'h0);
    apb(1'b1, `ODT_STAT_OFS, 32'hffffffff);
    apb(1'b0, `ODT_STAT_OFS, 32'h0);
    check("status", q, 32'h00000180);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", {q[30:0], e}, 32'h1);
    $display("done: registers");
  endtask : t_regs

  // Turn-on and turn-off latency over several CWL/AL pairs
  task automatic t_lat();
    logic [3:0] cw[3] = '{4'h5, 4'h5, 4'h8};
    logic [4:0] al[3] = '{5'h00, 5'h02, 5'h03};
    int odtl;
    for (int i = 0; i < 3; i++) begin
      odtl = cw[i] + al[i] - 2;
      set_cfg(3'h1, 2'h0, cw[i], al[i], 2'h0, 1'b0);
      pulse(8'h08, 1'b0, 1'b0);
      wait_for(1'b0, 1'b1, n);
      check("on latency", n, odtl + 2);
      check("lanes code", {term_en, rtt_code}, 32'h19);
      wait_for(1'b0, 1'b0, n);
      check("off latency", n, 8);
    end
    $display("done: latency");
  endtask : t_lat

  // Write strength window for every burst setting
  task automatic t_dyn();
    logic [1:0] bm[5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h3};
    logic b4[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int len[5] = '{6, 4, 4, 6, 6};
    for (int i = 0; i < 5; i++) begin
      set_cfg(3'h1, 2'h2, 4'h5, 5'h00, bm[i], 1'b0);
      pulse(8'h08, 1'b1, b4[i]);
      wait_for(1'b1, 1'b1, n);
      check("cnw latency", n, 3);
      check("wr code", {sel_wr, rtt_code}, 32'ha);
      wait_for(1'b1, 1'b0, n);
      check("wr hold", n, len[i]);
      check("nom back", rtt_code, 32'h1);
      wait_for(1'b0, 1'b0, n);
    end
    $display("done: dynamic");
  endtask : t_dyn

  // Drivers active cut termination; it returns when they release.
  // First burst keeps ODT high on purpose, to prove the gate itself.
  task automatic t_read();
    set_cfg(3'h1, 2'h0, 4'h5, 5'h00, 2'h0, 1'b0);
    pulse(8'h14, 1'b0, 1'b0);
    wait_for(1'b0, 1'b1, n);
    @(posedge clock_i);
    dq_drv <= 1'b1;
    @(posedge clock_i);
    #1;
    check("driving off", term_en, 32'h0);
    @(posedge clock_i);
    dq_drv <= 1'b0;
    @(posedge clock_i);
    #1;
    check("released on", term_en, 32'h3);
    wait_for(1'b0, 1'b0, n);
    // Legal burst: ODT already low, raised again only after release
    @(posedge clock_i);
    dq_drv <= 1'b1;
    repeat (4) @(posedge clock_i);
    dq_drv <= 1'b0;
    pulse(8'h08, 1'b0, 1'b0);
    wait_for(1'b0, 1'b1, n);
    check("after read", n, 5);
    wait_for(1'b0, 1'b0, n);
    $display("done: read");
  endtask : t_read

  // Precharge power-down with DLL frozen drops AL, kept DLL does not
  task automatic t_async();
    for (int k = 0; k < 2; k++) begin
      set_cfg(3'h1, 2'h0, 4'h5, 5'h02, 2'h0, k[0]);
      @(posedge clock_i);
      pd_pre <= 1'b1;
      dll_lock <= k[0];
      pulse(8'h08, 1'b0, 1'b0);
      wait_for(1'b0, 1'b1, n);
      check("pd latency", n, k ? 7 : 5);
      wait_for(1'b0, 1'b0, n);
      @(posedge clock_i);
      pd_pre <= 1'b0;
      dll_lock <= 1'b1;
    end
    $display("done: power-down");
  endtask : t_async

  // Cases where ODT or the write must be ignored
  task automatic t_off();
    set_cfg(3'h0, 2'h0, 4'h5, 5'h00, 2'h0, 1'b0);
    quiet("codes zero", 1'b1, 1'b1);
    set_cfg(3'h1, 2'h0, 4'h5, 5'h00, 2'h0, 1'b0);
    quiet("wr code zero", 1'b0, 1'b1);
    set_cfg(3'h1, 2'h2, 4'h5, 5'h00, 2'h0, 1'b0);
    self_ref <= 1'b1;
    // No command can be registered in self-refresh, so ODT alone
    quiet("self refresh", 1'b1, 1'b0);
    self_ref <= 1'b0;
    set_cfg(3'h1, 2'h0, 4'h5, 5'h00, 2'h0, 1'b0); // Write code zeroed
    dll_off <= 1'b1;
    dll_lock <= 1'b0;
    quiet("dll off", 1'b1, 1'b1);
    $display("done: ignored");
  endtask : t_off

  // Main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    check("reset out", {term_en, rtt_code, sel_wr}, 32'h0);
    reset_i <= 1'b0;
    t_regs();
    t_lat();
    t_dyn();
    t_read();
    t_async();
    t_off();
    complete_run();
  end
endmodule : dram_on_die_termination_ctrl_bench

// ===== dv/odt_host_model.sv
// Memory controller model: drives the ODT pin and write commands.
// Assumes start_i is a one-cycle request on clock_i from the bench.
`timescale 1ns/1ps
module odt_host_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Requests from the bench
  input wire logic start_i,
  input wire logic [7:0] len_i,
  input wire logic wr_i,
  input wire logic bc4_i,
  input wire logic dll_off_i,
  // Pins toward the device
  output logic odt_pin_o,
  output logic wr_cmd_o,
  output logic wr_bc4_o
);
  logic [7:0] hold_r; // High cycles left on ODT
  logic [7:0] need; // Shortest legal high time

  // Longer hold after a BL8 write, never under four
  always_comb need = (wr_i && !bc4_i) ? 8'h06 : 8'h04;

  // Pin driver; in DLL-off mode ODT is never raised
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      odt_pin_o <= 1'b0;
      hold_r <= 8'h00;
      wr_cmd_o <= 1'b0;
      wr_bc4_o <= 1'b0;
    end else if (start_i && !dll_off_i) begin
      odt_pin_o <= 1'b1;
      hold_r <= (len_i > need) ? len_i : need;
      wr_cmd_o <= wr_i;
      wr_bc4_o <= bc4_i;
    end else begin
      // Burst-size line means nothing outside a write: keep it moving
      wr_cmd_o <= 1'b0;
      wr_bc4_o <= ~wr_bc4_o;
      if (hold_r > 8'h01) begin
        hold_r <= hold_r - 8'h01;
      end else begin
        hold_r <= 8'h00;
        odt_pin_o <= 1'b0;
      end
    end
  end
endmodule : odt_host_model

// ===== verilog/odt_cfg.svh
// Constants for the on-die termination controller: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

// APB register byte offsets
`define ODT_CFG_OFS 12'h000
`define ODT_STAT_OFS 12'h004

// Widths of the packed register images
`define ODT_CFG_W 17
`define ODT_STAT_W 12

// Reset values of configuration fields
`define ODT_CWL_RST 4'h5
`define ODT_AL_RST 5'h00

// Latency arithmetic: latency = CWL (+ AL) - 2
`define ODT_LAT_SUB 6'h02
`define ODT_LAT_MIN 6'h02
`define ODT_LAT_MAX 6'h1f

// Write-strength hold after the strength switch (cwn - cnw)
`define ODT_CWN4_EXTRA 3'h4
`define ODT_CWN8_EXTRA 3'h6

`endif

// ===== verilog/odt_ctrl.sv
// On-die termination control for a x16 DRAM, with APB configuration.
// Assumes command decode, power state and driver state are on clock_i;
// only the ODT pin is asynchronous.
//
// Notes on behaviour
// - One ODT input terminates both byte lanes.
// - Self-refresh: termination off, ODT ignored.
// - All termination codes zero: ODT ignored.
// - Sampled ODT low off; high on unless disabled.
// - On/off uses write command decode only when the nominal code is zero.
// - Synchronous timing whenever DLL on and locked.
// - On/off follow ODT after the set latency.
// - Latency is CWL plus AL minus two.
// - Termination returns when output drivers release.
// - Nonzero write code enables dynamic switching.
// - Nominal and write codes from their fields.
// - Without writes, nominal strength, ODT timing.
// - Writes: write strength for four/six clocks.
// - Asynchronous mode skips the additive latency.
`timescale 1ns/1ps
`include "odt_cfg.svh"
module odt_ctrl #(
  parameter int LANES = 2,     // Byte lanes under one ODT pin
  parameter int MAX_LAT = 32   // Depth of the latency lines
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pin and device state
  input wire logic odt_pin_i,
  input wire logic wr_cmd_i,
  input wire logic wr_bc4_i,
  input wire logic self_refresh_i,
  input wire logic dll_locked_i,
  input wire logic pd_precharge_i,
  input wire logic dq_driving_i,
  // Termination outputs
  output logic [LANES-1:0] term_en_o,
  output logic [2:0] rtt_code_o,
  output logic sel_wr_o
);

  odt_pkg::cfg_t cfg_r;        // Configuration register
  odt_pkg::stat_t stat;        // Status image
  odt_pkg::odt_mode_t mode;    // Current timing mode
  logic odt_s;                 // Synchronised pin
  logic odt_in;                // Value entering the ODT line
  logic odt_active;            // Some termination code is nonzero
  logic dyn_en;                // Dynamic switching enabled
  logic [5:0] lat_sum;         // CWL plus any AL, before the subtraction
  logic [5:0] lat_raw;         // Unclamped latency
  logic [4:0] odtl;            // Latency in use
  logic [4:0] tap_idx;         // Line tap for the latency
  logic [MAX_LAT-1:0] odt_taps;
  logic [2*MAX_LAT-1:0] wr_taps;
  logic odt_tap;               // Delayed ODT
  logic wr_hit;                // Delayed write reaches switch point
  logic wr_hit_bc4;            // That write was a BC4
  logic [2:0] wr_cnt_r;        // Write-strength countdown
  logic sel_wr_nxt;
  logic term_nxt;
  logic wr_bc4_eff;            // Burst chop after mode decode
  logic apb_setup;
  logic apb_access;
  logic addr_cfg;
  logic addr_stat;

  // Pin crosses into the clock domain before anything looks at it
  odt_sync2 #(.W(1)) u_odt_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i(odt_pin_i),
    .sync_o(odt_s)
  );

  // Mode: synchronous while DLL locked, async if frozen in PD
  always_comb begin
    if (pd_precharge_i && !cfg_r.dll_pd_keep) begin
      mode = odt_pkg::MODE_ASYNC;
    end else if (dll_locked_i) begin
      mode = odt_pkg::MODE_SYNC;
    end else begin
      mode = odt_pkg::MODE_DLL_OFF; // Controller must have disabled it
    end
  end

  // Latency; async drops AL, and is clamped to 2..31
  always_comb begin
    if (mode == odt_pkg::MODE_ASYNC) begin
      lat_sum = {2'h0, cfg_r.cwl};
    end else begin
      lat_sum = {2'h0, cfg_r.cwl} + {1'b0, cfg_r.al};
    end
    lat_raw = lat_sum - `ODT_LAT_SUB;
    // Judge short sums before subtracting: a wrapped value would look long
    if (lat_sum < `ODT_LAT_SUB + `ODT_LAT_MIN) begin
      odtl = 5'(`ODT_LAT_MIN);
    end else if (lat_raw > `ODT_LAT_MAX) begin
      odtl = 5'(`ODT_LAT_MAX);
    end else begin
      odtl = lat_raw[4:0];
    end
    tap_idx = odtl - 5'(`ODT_LAT_SUB);
  end

  // Enables from the mode fields only, never from command decode
  assign odt_active = (|cfg_r.rtt_nom) || (|cfg_r.rtt_wr);
  assign dyn_en = |cfg_r.rtt_wr;
  assign odt_in = odt_s && odt_active && !self_refresh_i;

  // Burst chop: fixed modes override the per-command pick
  always_comb begin
    unique case (cfg_r.burst)
      odt_pkg::BURST_BC4: wr_bc4_eff = 1'b1;
      odt_pkg::BURST_OTF: wr_bc4_eff = wr_bc4_i;
      default: wr_bc4_eff = 1'b0;
    endcase
  end

  // ODT history; a line keeps every edge even when pulses overlap
  odt_delay_line #(.W(1), .D(MAX_LAT)) u_odt_line (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .din_i(odt_in),
    .taps_o(odt_taps)
  );

  // Write history with its burst chop flag
  odt_delay_line #(.W(2), .D(MAX_LAT)) u_wr_line (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .din_i({wr_bc4_eff, wr_cmd_i && dyn_en}),
    .taps_o(wr_taps)
  );

  assign odt_tap = odt_taps[tap_idx];
  assign wr_hit = wr_taps[2*tap_idx]; // Switch at WL-2
  assign wr_hit_bc4 = wr_taps[2*tap_idx+1];

  // Countdown of write strength; a new write reloads it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_cnt_r <= '0;
    end else if (wr_hit) begin
      wr_cnt_r <= wr_hit_bc4 ? `ODT_CWN4_EXTRA : `ODT_CWN8_EXTRA;
    end else if (wr_cnt_r != '0) begin
      wr_cnt_r <= wr_cnt_r - 3'h1;
    end
  end

  // Next strength and on/off decision
  always_comb begin
    sel_wr_nxt = wr_hit || (wr_cnt_r > 3'h1);
    // Selected code zero means that strength terminates nothing
    term_nxt = odt_tap && !self_refresh_i && !dq_driving_i
      && (sel_wr_nxt ? dyn_en : (|cfg_r.rtt_nom));
  end

  // Registered outputs: all lanes share the one decision
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      term_en_o <= '0;
      sel_wr_o <= 1'b0;
      rtt_code_o <= '0;
    end else begin
      term_en_o <= {LANES{term_nxt}};
      sel_wr_o <= sel_wr_nxt;
      rtt_code_o <= sel_wr_nxt ? {1'b0, cfg_r.rtt_wr} : cfg_r.rtt_nom;
    end
  end

  // APB decode
  assign apb_setup = psel_i && !penable_i;
  assign apb_access = psel_i && penable_i && pready_o;
  assign addr_cfg = (paddr_i == `ODT_CFG_OFS);
  assign addr_stat = (paddr_i == `ODT_STAT_OFS);

  // Status image
  always_comb begin
    stat.odtl = odtl;
    stat.odt_seen = odt_s;
    stat.async_mode = (mode == odt_pkg::MODE_ASYNC);
    stat.code = rtt_code_o;
    stat.sel_wr = sel_wr_o;
    stat.term_en = term_en_o[0];
  end

  // Configuration write on the access edge only
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r <= '{dll_pd_keep: 1'b0, burst: odt_pkg::BURST_BL8, al: `ODT_AL_RST,
                 cwl: `ODT_CWL_RST, rtt_wr: 2'h0, rtt_nom: 3'h0};
    end else if (apb_access && pwrite_i && addr_cfg) begin
      cfg_r <= odt_pkg::cfg_t'(pwdata_i[`ODT_CFG_W-1:0]);
    end
  end

  // Zero-wait answer: ready, data and error set up during the setup cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !addr_cfg && !addr_stat;
      if (apb_setup && !pwrite_i && addr_cfg) begin
        prdata_o <= 32'(cfg_r);
      end else if (apb_setup && !pwrite_i && addr_stat) begin
        prdata_o <= 32'(stat);
      end else begin
        prdata_o <= '0;
      end
    end
  end

  // Helper: cycles since the ODT line input last rose or fell
  logic odt_in_q_r;
  logic [5:0] rise_age_r;
  logic [5:0] fall_age_r;
  logic [4:0] odtl_q_r;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      odt_in_q_r <= 1'b0;
      rise_age_r <= 6'h3f;
      fall_age_r <= 6'h3f;
      odtl_q_r <= '0;
    end else begin
      odt_in_q_r <= odt_in;
      odtl_q_r <= odtl;
      rise_age_r <= (odt_in && !odt_in_q_r) ? 6'h01 :
        ((rise_age_r == 6'h3f) ? rise_age_r : rise_age_r + 6'h01);
      fall_age_r <= (!odt_in && odt_in_q_r) ? 6'h01 :
        ((fall_age_r == 6'h3f) ? fall_age_r : fall_age_r + 6'h01);
    end
  end

  lanes_equal_a: assert property (@(posedge clock_i) disable iff (reset_i)
    term_en_o == {LANES{term_en_o[0]}}) else $error("lanes disagree");
  sref_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
    self_refresh_i |=> !term_en_o[0]) else $error("termination on in self-refresh");
  disabled_ignore_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !odt_active |=> !odt_taps[0]) else $error("ODT taken while disabled");
  odt_low_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !odt_tap |=> !term_en_o[0]) else $error("termination on with ODT low");
  on_latency_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_age_r == {1'b0, odtl} && odtl == odtl_q_r && !self_refresh_i) |-> odt_tap)
    else $error("turn-on latency wrong");
  off_latency_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (fall_age_r == {1'b0, odtl} && odtl == odtl_q_r) |-> !odt_tap)
    else $error("turn-off latency wrong");
  sync_lat_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (mode == odt_pkg::MODE_SYNC && cfg_r.cwl + cfg_r.al < 6'h21
      && cfg_r.cwl + cfg_r.al > 6'h03)
    |-> {1'b0, odtl} == {2'h0, cfg_r.cwl} + {1'b0, cfg_r.al} - 6'h02)
    else $error("sync latency not CWL+AL-2");
  async_lat_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (mode == odt_pkg::MODE_ASYNC && cfg_r.cwl > 4'h3) |-> odtl == cfg_r.cwl - 4'h2)
    else $error("async latency includes AL");
  drive_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
    dq_driving_i |=> !term_en_o[0]) else $error("terminating while driving");
  wr_bc4_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (wr_hit && wr_hit_bc4) |=> sel_wr_o [*4]) else $error("BC4 write strength short");
  wr_bl8_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (wr_hit && !wr_hit_bc4) |=> sel_wr_o [*6]) else $error("BL8 write strength short");
  nom_code_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (!sel_wr_nxt && $stable(cfg_r.rtt_nom)) |=> rtt_code_o == $past(cfg_r.rtt_nom))
    else $error("nominal code not driven");
  no_dyn_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !dyn_en |=> !sel_wr_o || $past(wr_cnt_r != 3'h0)) else $error("write strength unarmed");

  bc4_seen_c: cover property (@(posedge clock_i) disable iff (reset_i) wr_hit && wr_hit_bc4);
  bl8_seen_c: cover property (@(posedge clock_i) disable iff (reset_i) wr_hit && !wr_hit_bc4);
  term_on_c: cover property (@(posedge clock_i) disable iff (reset_i) $rose(term_en_o[0]));
  async_c: cover property (@(posedge clock_i) disable iff (reset_i)
    mode == odt_pkg::MODE_ASYNC && odt_tap);

endmodule : odt_ctrl

// ===== verilog/odt_delay_line.sv
// Tapped shift line: tap k holds the input from k+1 clocks ago.
// Assumes the user picks one tap per cycle with a runtime index.
`timescale 1ns/1ps
module odt_delay_line #(
  parameter int W = 1,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Line
  input wire logic [W-1:0] din_i,
  output logic [D*W-1:0] taps_o
);

  // Shift by one word every clock; flops rather than RAM keep taps readable
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      taps_o <= '0;
    end else begin
      taps_o <= {taps_o[(D-1)*W-1:0], din_i};
    end
  end

endmodule : odt_delay_line

// ===== verilog/odt_pkg.sv
// Types shared by the termination controller and its register file.
// Assumes odt_cfg.svh supplies the widths used by the register images.
package odt_pkg;

  // Burst length selection, as held in the configuration register
  typedef enum logic [1:0] {
    BURST_BL8,
    BURST_OTF,
    BURST_BC4,
    BURST_RSV
  } burst_t;

  // ODT timing mode
  typedef enum logic [1:0] {
    MODE_SYNC,
    MODE_ASYNC,
    MODE_DLL_OFF
  } odt_mode_t;

  // Configuration register image, MSB first
  typedef struct packed {
    logic dll_pd_keep;   // Set: DLL kept on in precharge power-down
    burst_t burst;       // Fixed BL8, on-the-fly, fixed BC4
    logic [4:0] al;      // Additive latency
    logic [3:0] cwl;     // CAS write latency
    logic [1:0] rtt_wr;  // Write termination code
    logic [2:0] rtt_nom; // Nominal termination code
  } cfg_t;

  // Status register image, MSB first
  typedef struct packed {
    logic [4:0] odtl;    // Latency in use
    logic odt_seen;      // Synchronised ODT pin
    logic async_mode;    // Asynchronous timing in use
    logic [2:0] code;    // Strength code driven out
    logic sel_wr;        // Write strength selected
    logic term_en;       // Termination on
  } stat_t;

endpackage : odt_pkg

// ===== verilog/odt_sync2.sv
// Two-flop synchroniser for levels that arrive from package pins.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/1ps
module odt_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r; // First stage, read only by the second

  // Two stages; nothing but the second stage reads the first
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : odt_sync2
